// file: hw/ofsa_pkg.sv
// Shared constants for the output fault and status aggregator
package ofsa_pkg;
   localparam int          OFSA_NUM_CH        = 6;
   localparam int          OFSA_CLK_HZ        = 50_000_000;
   localparam int          OFSA_RPI_US        = 1000;
   localparam int          OFSA_RPI_CYCLES    = OFSA_CLK_HZ / 1_000_000 * OFSA_RPI_US;
   localparam int          OFSA_FULL_SCALE    = 65535;
   // Hold window is 0.1 % of full scale, held as parts per thousand
   localparam int          OFSA_HOLD_PER_MILLE = 1;
   localparam int          OFSA_MILLE         = 1000;

   // Register byte offsets
   localparam logic [7:0]  OFSA_ADR_MODULE    = 8'h00;
   localparam logic [7:0]  OFSA_ADR_CHANNEL   = 8'h04;
   localparam logic [7:0]  OFSA_ADR_STATUS0   = 8'h08;
   localparam logic [7:0]  OFSA_ADR_STATUS5   = 8'h1C;
   localparam logic [7:0]  OFSA_ADR_LATCH_EN  = 8'h20;
   localparam logic [7:0]  OFSA_ADR_UNLATCH   = 8'h24;
   localparam logic [7:0]  OFSA_ADR_CONTROL   = 8'h28;

   // Module summary word bit positions
   localparam int          OFSA_MF_ANALOG_GRP = 15;
   localparam int          OFSA_MF_UNUSED     = 14;
   localparam int          OFSA_MF_OUTPUT_GRP = 13;
   localparam int          OFSA_MF_CALIBRATING = 12;
   localparam int          OFSA_MF_CAL_ERR    = 11;

   // Channel condition word bit positions
   localparam int          OFSA_CS_NAN        = 5;
   localparam int          OFSA_CS_CAL_ERR    = 4;
   localparam int          OFSA_CS_HOLD       = 3;
   localparam int          OFSA_CS_SLEW       = 2;
   localparam int          OFSA_CS_LOW        = 1;
   localparam int          OFSA_CS_HIGH       = 0;

   // Forced channel fault patterns
   localparam logic [15:0] OFSA_CF_CAL_PATTERN  = 16'h003F;
   localparam logic [15:0] OFSA_CF_COMM_PATTERN = 16'hFFFF;

   // IEEE single precision fields
   localparam int          OFSA_FLT_EXP_MSB   = 30;
   localparam int          OFSA_FLT_EXP_LSB   = 23;
   localparam int          OFSA_FLT_MAN_MSB   = 22;

   // Reset values of software registers and the publish enable bit of the control word
   localparam logic [5:0]  OFSA_LATCH_RST     = 6'h00;
   localparam logic        OFSA_PUB_EN_RST    = 1'b1;
   localparam int          OFSA_CTRL_PUB_EN   = 0;
endpackage

// file: hw/ofsa_channel_cell.sv
// Per-channel condition word and output value holder
module ofsa_channel_cell
   import ofsa_pkg::*;
#(
   parameter int FULL_SCALE = OFSA_FULL_SCALE
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        latch_en_i,
   input  wire logic        unlatch_i,
   input  wire logic        above_high_i,
   input  wire logic        below_low_i,
   input  wire logic        slew_exceed_i,
   input  wire logic        cal_error_i,
   input  wire logic        hold_start_i,
   input  wire logic        req_valid_i,
   input  wire logic [31:0] req_value_i,
   input  wire logic [31:0] echo_value_i,
   output logic      [7:0]  status_o,
   output logic      [31:0] drive_value_o
);

   localparam logic [32:0] HOLD_TOL = 33'(FULL_SCALE * OFSA_HOLD_PER_MILLE / OFSA_MILLE);

   logic        high_q;
   logic        low_q;
   logic        slew_q;
   logic        hold_q;
   logic        nan_q;
   logic        calerr_q;
   logic        req_nan;
   logic [32:0] diff;
   logic [32:0] diff_abs;
   logic        in_window;

   assign req_nan   = (&req_value_i[OFSA_FLT_EXP_MSB:OFSA_FLT_EXP_LSB])
                      && (|req_value_i[OFSA_FLT_MAN_MSB:0]);
   assign diff      = {req_value_i[31], req_value_i} - {echo_value_i[31], echo_value_i};
   assign diff_abs  = diff[32] ? (~diff + 33'h0_0000_0001) : diff;
   assign in_window = (diff_abs <= HOLD_TOL);

   ////////////////////////////////////////////////////////////////////////////
   // Alarms follow the condition; with latching they stay until unlatched
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         high_q <= 1'b0;
         low_q  <= 1'b0;
         slew_q <= 1'b0;
      end
      else
      begin
         // A live condition wins over an unlatch in the same cycle
         high_q <= above_high_i  | (latch_en_i & high_q & ~unlatch_i);
         low_q  <= below_low_i   | (latch_en_i & low_q  & ~unlatch_i);
         slew_q <= slew_exceed_i | (latch_en_i & slew_q & ~unlatch_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         calerr_q <= 1'b0;
      else
         calerr_q <= cal_error_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hold flag: start wins over release
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hold_q <= 1'b0;
      else if (hold_start_i)
         hold_q <= 1'b1;
      else if (req_valid_i && !req_nan && in_window)
         hold_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Invalid float keeps the last good output value
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nan_q         <= 1'b0;
         drive_value_o <= 32'h0000_0000;
      end
      else if (req_valid_i)
      begin
         nan_q <= req_nan;
         if (!req_nan && !hold_q)
            drive_value_o <= req_value_i;
      end
   end

   // Bits 7 and 6 tie low
   assign status_o = {2'b00, nan_q, calerr_q, hold_q, slew_q, low_q, high_q};

endmodule

// file: hw/ofsa_top.sv
// Fault and status aggregator for a six-channel analog output module
////////////////////////////////////////////////////////////////////////////////
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
module ofsa_top
   import ofsa_pkg::*;
#(
   parameter int RPI_CYCLES = OFSA_RPI_CYCLES,
   parameter int FULL_SCALE = OFSA_FULL_SCALE
)
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [7:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   // Channel conditions
   input  wire logic                      comm_lost_i,
   input  wire logic [OFSA_NUM_CH-1:0]    cal_active_i,
   input  wire logic [OFSA_NUM_CH-1:0]    cal_error_i,
   input  wire logic [OFSA_NUM_CH-1:0]    above_high_i,
   input  wire logic [OFSA_NUM_CH-1:0]    below_low_i,
   input  wire logic [OFSA_NUM_CH-1:0]    slew_exceed_i,
   input  wire logic [OFSA_NUM_CH-1:0]    hold_start_i,
   input  wire logic [OFSA_NUM_CH-1:0]    req_valid_i,
   input  wire logic [OFSA_NUM_CH*32-1:0] req_value_i,
   input  wire logic [OFSA_NUM_CH*32-1:0] echo_value_i,
   // Channel drive
   output logic      [OFSA_NUM_CH*32-1:0] drive_value_o,
   // Published frame
   output logic                           frame_valid_o,
   output logic      [15:0]               frame_module_o,
   output logic      [15:0]               frame_channel_o,
   output logic      [OFSA_NUM_CH*8-1:0]  frame_status_o,
   output logic      [OFSA_NUM_CH*32-1:0] frame_echo_o
);

   localparam int         RPI_W    = (RPI_CYCLES > 2) ? $clog2(RPI_CYCLES) : 1;
   localparam logic [RPI_W-1:0] RPI_LAST = RPI_W'(RPI_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   generate
      if (RPI_CYCLES < 2)
      begin : g_bad_rpi
         $error("RPI_CYCLES must be at least 2");
      end

      if (FULL_SCALE < OFSA_MILLE)
      begin : g_bad_fs
         $error("FULL_SCALE too small for a 0.1 percent window");
      end

      // The index into the condition words is three bits wide
      if (OFSA_NUM_CH > 8)
      begin : g_bad_ch
         $error("OFSA_NUM_CH above 8");
      end

      if (OFSA_ADR_STATUS5 != OFSA_ADR_STATUS0 + 8'(4 * (OFSA_NUM_CH - 1)))
      begin : g_bad_map
         $error("Condition word map does not match OFSA_NUM_CH");
      end
   endgenerate

   logic [7:0]             status   [OFSA_NUM_CH];
   logic [OFSA_NUM_CH-1:0] limit_fault;
   logic [OFSA_NUM_CH-1:0] ch_calerr;
   logic [5:0]             latch_en_q;
   logic [5:0]             unlatch_q;
   logic                   pub_en_q;
   logic [15:0]            chf_d;
   logic [15:0]            chf_q;
   logic [15:0]            mf_d;
   logic [15:0]            mf_q;
   logic [RPI_W-1:0]       rpi_cnt_q;
   logic                   rpi_tick;
   logic                   wb_req;
   logic                   wb_wr;
   logic [31:0]            rd_d;
   logic [7:0]             st_off;
   logic [2:0]             st_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Channel cells
   generate
      for (genvar i = 0; i < OFSA_NUM_CH; i++)
      begin : g_ch
         ofsa_channel_cell #(
            .FULL_SCALE    (FULL_SCALE)
         ) u_cell (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .latch_en_i    (latch_en_q[i]),
            .unlatch_i     (unlatch_q[i]),
            .above_high_i  (above_high_i[i]),
            .below_low_i   (below_low_i[i]),
            .slew_exceed_i (slew_exceed_i[i]),
            .cal_error_i   (cal_error_i[i]),
            .hold_start_i  (hold_start_i[i]),
            .req_valid_i   (req_valid_i[i]),
            .req_value_i   (req_value_i[i*32 +: 32]),
            .echo_value_i  (echo_value_i[i*32 +: 32]),
            .status_o      (status[i]),
            .drive_value_o (drive_value_o[i*32 +: 32])
         );

         // NaN, hold and slew stay out of the channel fault word
         assign limit_fault[i] = status[i][OFSA_CS_LOW] | status[i][OFSA_CS_HIGH];
         assign ch_calerr[i]   = status[i][OFSA_CS_CAL_ERR];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Channel fault word and module summary
   // Link loss outranks calibration, so the owner sees FFFF first
   always_comb
   begin
      chf_d = 16'h0000;
      if (comm_lost_i)
         chf_d = OFSA_CF_COMM_PATTERN;
      else if (|cal_active_i)
         chf_d = OFSA_CF_CAL_PATTERN;
      else
         chf_d[OFSA_NUM_CH-1:0] = limit_fault;
   end

   always_comb
   begin
      mf_d                      = 16'h0000;
      // Group bits track the word directly, so they drop with it
      mf_d[OFSA_MF_ANALOG_GRP]  = |chf_d;
      mf_d[OFSA_MF_OUTPUT_GRP]  = |chf_d;
      mf_d[OFSA_MF_CALIBRATING] = |cal_active_i;
      mf_d[OFSA_MF_CAL_ERR]     = |ch_calerr;
      mf_d[OFSA_MF_UNUSED]      = 1'b0;
   end

   // Both words register on the same edge, so summary and fault word agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chf_q <= 16'h0000;
         mf_q  <= 16'h0000;
      end
      else
      begin
         chf_q <= chf_d;
         mf_q  <= mf_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Publish interval divider
   // The rate is an enable pulse on the one clock, never a derived clock
   assign rpi_tick = (rpi_cnt_q == RPI_LAST);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rpi_cnt_q <= '0;
      else if (rpi_tick)
         rpi_cnt_q <= '0;
      else
         rpi_cnt_q <= rpi_cnt_q + RPI_W'(1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Published frame: one snapshot of all words with the echo data
   // Registered words are copied; fault word and summary bits made from the condition words lag those words by one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         frame_valid_o <= 1'b0;
      else
         frame_valid_o <= rpi_tick & pub_en_q;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frame_module_o  <= 16'h0000;
         frame_channel_o <= 16'h0000;
         frame_echo_o    <= '0;
      end
      else if (rpi_tick && pub_en_q)
      begin
         frame_module_o  <= mf_q;
         frame_channel_o <= chf_q;
         frame_echo_o    <= echo_value_i;
      end
   end

   generate
      for (genvar j = 0; j < OFSA_NUM_CH; j++)
      begin : g_frame
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               frame_status_o[j*8 +: 8] <= 8'h00;
            else if (rpi_tick && pub_en_q)
               frame_status_o[j*8 +: 8] <= status[j];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the request, dropped after one cycle
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
   assign st_off = wb_adr_i - OFSA_ADR_STATUS0;
   assign st_idx = st_off[4:2];

   // Registered ack: one wait state, and never two acks in a row
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   // Writes land on the edge that raises ack, while the request still stands
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latch_en_q <= OFSA_LATCH_RST;
      else if (wb_wr && wb_adr_i == OFSA_ADR_LATCH_EN)
         latch_en_q <= wb_dat_i[5:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pub_en_q <= OFSA_PUB_EN_RST;
      else if (wb_wr && wb_adr_i == OFSA_ADR_CONTROL)
         pub_en_q <= wb_dat_i[OFSA_CTRL_PUB_EN];
   end

   // Unlatch is a one-cycle strobe; a write of zero does nothing
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         unlatch_q <= 6'h00;
      else if (wb_wr && wb_adr_i == OFSA_ADR_UNLATCH)
         unlatch_q <= wb_dat_i[5:0];
      else
         unlatch_q <= 6'h00;
   end

   // Unmapped and write-only addresses read zero but still ack
   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (wb_adr_i == OFSA_ADR_MODULE)
         rd_d = {16'h0000, mf_q};
      else if (wb_adr_i == OFSA_ADR_CHANNEL)
         rd_d = {16'h0000, chf_q};
      else if (wb_adr_i >= OFSA_ADR_STATUS0 && wb_adr_i <= OFSA_ADR_STATUS5
               && wb_adr_i[1:0] == 2'b00)
         rd_d = {24'h00_0000, status[st_idx]};
      else if (wb_adr_i == OFSA_ADR_LATCH_EN)
         rd_d = {26'h000_0000, latch_en_q};
      else if (wb_adr_i == OFSA_ADR_CONTROL)
         rd_d = {31'h0000_0000, pub_en_q};
      else
         rd_d = 32'h0000_0000;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (wb_req && !wb_we_i)
         wb_dat_o <= rd_d;
      else
         wb_dat_o <= 32'h0000_0000;
   end

endmodule

// file: verif/ofsa_checker.sv
// Port-level assertions for the fault and status aggregator
module ofsa_checker
   import ofsa_pkg::*;
#(
   parameter int RPI_CYCLES = OFSA_RPI_CYCLES
)
(
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic [31:0]              wb_dat_o,
   input  wire logic                     wb_ack_o,
   input  wire logic                     comm_lost_i,
   input  wire logic                     frame_valid_o,
   input  wire logic [15:0]              frame_module_o,
   input  wire logic [15:0]              frame_channel_o,
   input  wire logic [OFSA_NUM_CH*8-1:0] frame_status_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic      [15:0] gap_q;
   logic             seen_q;
   wire logic [11:0] pad_w = {frame_status_o[47:46], frame_status_o[39:38],
      frame_status_o[31:30], frame_status_o[23:22], frame_status_o[15:14], frame_status_o[7:6]};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   // Gap since last frame; a disabled publisher skips whole periods
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         gap_q <= 16'h0000;
      else if (frame_valid_o)
         gap_q <= 16'h0001;
      else
         gap_q <= gap_q + 16'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         seen_q <= 1'b0;
      else if (frame_valid_o)
         seen_q <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   chk_summary_unused: assert property (frame_module_o[OFSA_MF_UNUSED] == 1'b0)
      else $error("summary bit 14 set");
   chk_status_pad: assert property (pad_w == 12'h000)
      else $error("condition word bits 7 or 6 set");
   chk_group_bits: assert property (frame_module_o[15] == (frame_channel_o != 16'h0000)
      && frame_module_o[13] == (frame_channel_o != 16'h0000))
      else $error("group bits disagree with fault word");
   chk_cal_force: assert property (frame_module_o[12] |-> frame_channel_o == 16'h003F
      || frame_channel_o == 16'hFFFF)
      else $error("calibrating without forced pattern");
   chk_comm_force: assert property (frame_valid_o && $past(comm_lost_i, 1)
      && $past(comm_lost_i, 2) && $past(comm_lost_i, 3) && $past(comm_lost_i, 4)
      |-> frame_channel_o == 16'hFFFF)
      else $error("link lost without all-ones pattern");
   chk_frame_period: assert property (frame_valid_o && seen_q |-> gap_q % RPI_CYCLES == 0)
      else $error("frame spacing off period");
   cov_comm_frame: cover property (frame_valid_o && frame_channel_o == 16'hFFFF);
   cov_cal_frame: cover property (frame_valid_o && frame_module_o[12]);
   cov_read_data: cover property (wb_ack_o && wb_dat_o != 32'h0000_0000);
endmodule

bind ofsa_top ofsa_checker #(.RPI_CYCLES(RPI_CYCLES)) u_ofsa_checker (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .comm_lost_i(comm_lost_i), .frame_valid_o(frame_valid_o),
   .frame_module_o(frame_module_o), .frame_channel_o(frame_channel_o),
   .frame_status_o(frame_status_o));

// file: verif/ofsa_owner_model.sv
// Owner controller model that consumes the published frames
module ofsa_owner_model
   import ofsa_pkg::*;
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      frame_valid_i,
   input  wire logic [15:0]               module_i,
   input  wire logic [15:0]               channel_i,
   input  wire logic [OFSA_NUM_CH*32-1:0] echo_i,
   output logic      [15:0]               frames_o,
   output logic      [15:0]               module_o,
   output logic      [15:0]               channel_o,
   output logic      [31:0]               echo2_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Copies are taken on the pulse only; words between pulses are not trusted
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         frames_o <= 16'h0000;
      else if (frame_valid_i)
      begin
         frames_o  <= frames_o + 16'h0001;
         module_o  <= module_i;
         channel_o <= channel_i;
         echo2_o   <= echo_i[95:64];
      end
   end
endmodule

// file: verif/ofsa_top_bench.sv
// Self-checking bench for the fault and status aggregator
module ofsa_top_bench
   import ofsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RPI = 8;
   typedef struct packed {
      logic        cm;
      logic [5:0]  cal, ce, hi, lo, sl;
      logic [15:0] m, c;
      logic [7:0]  s;
   } ofsa_row_s;
   ofsa_row_s          rows [8];
   logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, comm_lost_i, wb_ack_o;
   logic [7:0]         wb_adr_i;
   logic [3:0]         wb_sel_i;
   logic [31:0]        wb_dat_i, wb_dat_o, q;
   logic [5:0]         cal_active_i, cal_error_i, above_high_i, below_low_i;
   logic [5:0]         slew_exceed_i, hold_start_i, req_valid_i;
   logic [191:0]       req_value_i, echo_value_i, drive_value_o, frame_echo_o;
   logic               frame_valid_o;
   logic [15:0]        frame_module_o, frame_channel_o, frames, own_m, own_c;
   logic [47:0]        frame_status_o;
   logic [31:0]        own_echo;
   int                 failures, n_tests, n;
   ofsa_top #(.RPI_CYCLES(RPI)) u_ofsa_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .comm_lost_i(comm_lost_i), .cal_active_i(cal_active_i), .cal_error_i(cal_error_i),
      .above_high_i(above_high_i), .below_low_i(below_low_i), .slew_exceed_i(slew_exceed_i),
      .hold_start_i(hold_start_i), .req_valid_i(req_valid_i), .req_value_i(req_value_i),
      .echo_value_i(echo_value_i), .drive_value_o(drive_value_o),
      .frame_valid_o(frame_valid_o), .frame_module_o(frame_module_o),
      .frame_channel_o(frame_channel_o), .frame_status_o(frame_status_o),
      .frame_echo_o(frame_echo_o));
   ofsa_owner_model u_ofsa_owner_model (.clk_i(clk_i), .rst_i(rst_i),
      .frame_valid_i(frame_valid_o), .module_i(frame_module_o), .channel_i(frame_channel_o),
      .echo_i(frame_echo_o), .frames_o(frames), .module_o(own_m), .channel_o(own_c),
      .echo2_o(own_echo));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Entered just after a rising edge; request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
      if (n >= 20)
      begin
         failures++;
         stop_test();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
      check(nm, q, exp);
   endtask
   task automatic req2(input logic [31:0] v);
      req_value_i[95:64] <= v;
      req_valid_i        <= 6'h04;
      @(posedge clk_i);
      req_valid_i <= 6'h00;
      repeat (3) @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {comm_lost_i, cal_active_i, cal_error_i, above_high_i, below_low_i} = '0;
      {slew_exceed_i, hold_start_i, req_valid_i, req_value_i} = '0;
      echo_value_i = {6{32'h3F80_0000}};
      failures = 0;
      n_tests = 0;
      rst_i = 1'b1;
      rows = '{'{1'b0, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 16'h0000, 16'h0000, 8'h00},
               '{1'b0, 6'h00, 6'h00, 6'h04, 6'h00, 6'h00, 16'hA000, 16'h0004, 8'h01},
               '{1'b0, 6'h00, 6'h00, 6'h00, 6'h20, 6'h04, 16'hA000, 16'h0020, 8'h04},
               '{1'b0, 6'h00, 6'h04, 6'h00, 6'h00, 6'h00, 16'h0800, 16'h0000, 8'h10},
               '{1'b0, 6'h01, 6'h00, 6'h04, 6'h00, 6'h00, 16'hB000, 16'h003F, 8'h01},
               '{1'b1, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00, 16'hB000, 16'hFFFF, 8'h00},
               '{1'b1, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 16'hA000, 16'hFFFF, 8'h00},
               '{1'b0, 6'h00, 6'h02, 6'h01, 6'h00, 6'h00, 16'hA800, 16'h0001, 8'h00}};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFSA_ADR_CONTROL, 32'h0000_0001, "publish");
      rd(OFSA_ADR_LATCH_EN, 32'h0000_0000, "latch");
      foreach (rows[i])
      begin
         {comm_lost_i, cal_active_i, cal_error_i} <= {rows[i].cm, rows[i].cal, rows[i].ce};
         {above_high_i, below_low_i, slew_exceed_i} <= {rows[i].hi, rows[i].lo, rows[i].sl};
         repeat (3) @(posedge clk_i);
         rd(OFSA_ADR_MODULE, {16'h0000, rows[i].m}, "module");
         rd(OFSA_ADR_CHANNEL, {16'h0000, rows[i].c}, "channel");
         rd(OFSA_ADR_STATUS0 + 8'h08, {24'h00_0000, rows[i].s}, "status2");
      end
      // Publishing off must silence frames; sel lane 0 clear must not write
      wb(1'b1, OFSA_ADR_CONTROL, 4'hE, 32'h0000_0000);
      rd(OFSA_ADR_CONTROL, 32'h0000_0001, "sel");
      wb(1'b1, OFSA_ADR_CONTROL, 4'hF, 32'h0000_0000);
      n = frames;
      repeat (3 * RPI) @(posedge clk_i);
      check("silent", frames, n[15:0]);
      wb(1'b1, OFSA_ADR_CONTROL, 4'hF, 32'h0000_0001);
      n = frames;
      repeat (2 * RPI) @(posedge clk_i);
      check("frames", {15'h0000, frames != n[15:0]}, 32'h0000_0001);
      check("own_m", own_m, 32'h0000_A800);
      check("own_c", own_c, 32'h0000_0001);
      check("own_echo", own_echo, 32'h3F80_0000);
      check("own_s", {16'h0000, frame_status_o[15:0]}, 32'h0000_1001);
      wb(1'b1, OFSA_ADR_MODULE, 4'hF, 32'h0000_FFFF);
      rd(OFSA_ADR_MODULE, 32'h0000_A800, "ro");
      wb(1'b1, 8'h30, 4'hF, 32'hFFFF_FFFF);
      rd(8'h30, 32'h0000_0000, "unmapped");
      {cal_error_i, above_high_i} <= 12'h000;
      wb(1'b1, OFSA_ADR_LATCH_EN, 4'hF, 32'h0000_0004);
      above_high_i <= 6'h04;
      below_low_i  <= 6'h01;
      repeat (3) @(posedge clk_i);
      {above_high_i, below_low_i} <= 12'h000;
      repeat (3) @(posedge clk_i);
      rd(OFSA_ADR_STATUS0 + 8'h08, 32'h0000_0001, "latched");
      rd(OFSA_ADR_CHANNEL, 32'h0000_0004, "latch_cf");
      rd(OFSA_ADR_STATUS0, 32'h0000_0000, "follow");
      wb(1'b1, OFSA_ADR_UNLATCH, 4'hF, 32'h0000_0004);
      repeat (3) @(posedge clk_i);
      rd(OFSA_ADR_STATUS0 + 8'h08, 32'h0000_0000, "unlatched");
      req2(32'h3F80_0000);
      check("drive", drive_value_o[95:64], 32'h3F80_0000);
      req2(32'h7FC0_0000);
      check("nan_keep", drive_value_o[95:64], 32'h3F80_0000);
      hold_start_i <= 6'h04;
      @(posedge clk_i);
      hold_start_i <= 6'h00;
      repeat (3) @(posedge clk_i);
      rd(OFSA_ADR_STATUS0 + 8'h08, 32'h0000_0028, "nan_hold");
      // Window is 65 counts: 0x100 away keeps holding, 0x10 away releases
      req2(32'h3F80_0100);
      rd(OFSA_ADR_STATUS0 + 8'h08, 32'h0000_0008, "hold");
      check("hold_keep", drive_value_o[95:64], 32'h3F80_0000);
      req2(32'h3F80_0010);
      rd(OFSA_ADR_STATUS0 + 8'h08, 32'h0000_0000, "release");
      above_high_i <= 6'h01;
      wb(1'b1, OFSA_ADR_LATCH_EN, 4'hF, 32'h0000_003F);
      repeat (2 * RPI) @(posedge clk_i);
      check("pre_rst", frame_channel_o, 32'h0000_0001);
      wb(1'b1, OFSA_ADR_CONTROL, 4'hF, 32'h0000_0000);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("rst_frame", {frame_module_o, frame_channel_o}, 32'h0000_0000);
      check("rst_drive", drive_value_o[95:64], 32'h0000_0000);
      rd(OFSA_ADR_CONTROL, 32'h0000_0001, "rst_pub");
      rd(OFSA_ADR_LATCH_EN, 32'h0000_0000, "rst_latch");
      stop_test();
   end
endmodule
